// *** rtl/sfp_pkg.sv ***
package sfp_pkg;

  localparam int AW     = 8;
  localparam int DW     = 32;
  localparam int IDX_W  = 4;
  localparam int DEPTH  = 16;
  localparam int RCNT_W = 16;

  // word offsets, byte addresses
  localparam logic [AW-1:0] OFF_SIG  = 8'h00;
  localparam logic [AW-1:0] OFF_REV  = 8'h04;
  localparam logic [AW-1:0] OFF_HDR0 = 8'h08;
  localparam logic [AW-1:0] OFF_HDR1 = 8'h0C;
  localparam logic [AW-1:0] OFF_TBL1 = 8'h30;
  localparam logic [AW-1:0] OFF_TBL2 = 8'h34;
  localparam logic [AW-1:0] OFF_TBL3 = 8'h38;
  localparam logic [AW-1:0] OFF_TBL4 = 8'h3C;
  localparam logic [AW-1:0] ROM_TOP  = 8'h40;
  localparam logic [AW-1:0] OFF_CTRL = 8'h40;
  localparam logic [AW-1:0] OFF_STAT = 8'h44;
  localparam logic [AW-1:0] OFF_RCNT = 8'h48;
  localparam logic [AW-1:0] OFF_RADR = 8'h4C;
  localparam logic [AW-1:0] OFF_CSUM = 8'h50;

  // header bytes
  localparam logic [7:0] SIG_B0    = 8'h53;
  localparam logic [7:0] SIG_B1    = 8'h46;
  localparam logic [7:0] SIG_B2    = 8'h44;
  localparam logic [7:0] SIG_B3    = 8'h50;
  localparam logic [7:0] REV_MINOR = 8'h06;
  localparam logic [7:0] REV_MAJOR = 8'h01;
  localparam logic [7:0] HDR_COUNT = 8'h00;
  localparam logic [7:0] FILL_B    = 8'hFF;
  localparam logic [7:0] PID_LSB   = 8'h00;
  localparam logic [7:0] PID_MSB   = 8'hFF;
  localparam logic [7:0] PT_MINOR  = 8'h06;
  localparam logic [7:0] PT_MAJOR  = 8'h01;
  localparam logic [7:0] PT_LEN    = 8'h10;
  localparam logic [7:0] PTR_B0    = 8'h30;
  localparam logic [7:0] PTR_B1    = 8'h00;
  localparam logic [7:0] PTR_B2    = 8'h00;

  // basic table fields
  localparam logic [1:0] ERASE_GRAN = 2'h1;
  localparam logic       WR_GRAN    = 1'h1;
  localparam logic       VOL_BP     = 1'h0;
  localparam logic       WREN_SEL   = 1'h0;
  localparam logic [2:0] UNUSED3    = 3'h7;
  localparam logic [7:0] ERASE4K_OP = 8'h20;
  localparam logic       RD112      = 1'h1;
  localparam logic [1:0] ADDR_MODE  = 2'h1;
  localparam logic       DTR_OK     = 1'h1;
  localparam logic       RD122      = 1'h1;
  localparam logic       RD144      = 1'h1;
  localparam logic       RD114      = 1'h1;
  localparam logic       UNUSED1    = 1'h1;
  localparam logic [31:0] DENSITY   = 32'h07FFFFFF;
  localparam logic [2:0] M144 = 3'h2;
  localparam logic [4:0] D144 = 5'h04;
  localparam logic [7:0] O144 = 8'hEB;
  localparam logic [2:0] M114 = 3'h0;
  localparam logic [4:0] D114 = 5'h08;
  localparam logic [7:0] O114 = 8'h6B;
  localparam logic [2:0] M112 = 3'h0;
  localparam logic [4:0] D112 = 5'h08;
  localparam logic [7:0] O112 = 8'h3B;
  localparam logic [2:0] M122 = 3'h4;
  localparam logic [4:0] D122 = 5'h00;
  localparam logic [7:0] O122 = 8'hBB;

  // little-endian words: lowest address in bits 7:0
  localparam logic [DW-1:0] W_SIG  = {SIG_B3, SIG_B2, SIG_B1, SIG_B0};
  localparam logic [DW-1:0] W_REV  =
    {FILL_B, HDR_COUNT, REV_MAJOR, REV_MINOR};
  localparam logic [DW-1:0] W_HDR0 = {PT_LEN, PT_MAJOR, PT_MINOR, PID_LSB};
  localparam logic [DW-1:0] W_HDR1 = {PID_MSB, PTR_B2, PTR_B1, PTR_B0};
  localparam logic [DW-1:0] W_TBL1 = {FILL_B, UNUSED1, RD114, RD144,
    RD122, DTR_OK, ADDR_MODE, RD112, ERASE4K_OP, UNUSED3, WREN_SEL,
    VOL_BP, WR_GRAN, ERASE_GRAN};
  localparam logic [DW-1:0] W_TBL2 = DENSITY;
  localparam logic [DW-1:0] W_TBL3 = {O114, M114, D114, O144, M144, D144};
  localparam logic [DW-1:0] W_TBL4 = {O122, M122, D122, O112, M112, D112};
  localparam logic [DW-1:0] W_HOLE = 32'hFFFFFFFF;

  // own registers
  localparam int CTRL_CNT_EN = 0;
  localparam int CTRL_RESCAN = 1;
  localparam logic CTRL_CNT_EN_RST = 1'h1;
  localparam int STAT_REFUSED = 2;

  typedef struct packed {
    logic refused;
    logic sig_ok;
    logic scan_done;
  } sfp_stat_t;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'h0,
    SCAN_RUN  = 2'h1,
    SCAN_DONE = 2'h3
  } sfp_scan_t;

  function automatic logic [DW-1:0] rom_word(input logic [IDX_W-1:0] i);
    case (i)
      4'h0:    rom_word = W_SIG;
      4'h1:    rom_word = W_REV;
      4'h2:    rom_word = W_HDR0;
      4'h3:    rom_word = W_HDR1;
      4'hC:    rom_word = W_TBL1;
      4'hD:    rom_word = W_TBL2;
      4'hE:    rom_word = W_TBL3;
      4'hF:    rom_word = W_TBL4;
      default: rom_word = W_HOLE;
    endcase
  endfunction : rom_word

endpackage : sfp_pkg

// *** rtl/sfp_rom_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfp_rom_mem #(
  parameter int DEPTH = sfp_pkg::DEPTH,
  parameter int IDX_W = sfp_pkg::IDX_W,
  parameter int DW    = sfp_pkg::DW
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             rd_en,
  input  wire logic             rom_hit,
  input  wire logic [IDX_W-1:0] index,
  input  wire logic [DW-1:0]    aux_word,
  output var  logic [DW-1:0]    q
);

  logic [DW-1:0] table_w [DEPTH];

  // contents fixed at build time; no write path exists
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    assign table_w[i] = sfp_pkg::rom_word(IDX_W'(i));
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else if (rd_en) begin
      q <= rom_hit ? table_w[index] : aux_word;
    end
  end

endmodule : sfp_rom_mem
`default_nettype wire

// *** rtl/sfp_param_rom.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfp_param_rom #(
  parameter int AW     = sfp_pkg::AW,
  parameter int DW     = sfp_pkg::DW,
  parameter int RCNT_W = sfp_pkg::RCNT_W
) (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output var  logic [DW-1:0] rdata,
  output var  logic          scan_ok
);

  localparam logic [sfp_pkg::IDX_W-1:0] IDX_LAST = '1;
  localparam logic [sfp_pkg::IDX_W-1:0] IDX_ONE  = 4'h1;
  localparam logic [RCNT_W-1:0]         RCNT_MAX = '1;
  localparam logic [RCNT_W-1:0]         RCNT_ONE = 16'h0001;

  logic                          rom_hit;
  logic                          refuse_evt;
  logic                          cnt_en;
  logic                          rescan;
  logic                          clr_refused;
  logic [RCNT_W-1:0]             refuse_cnt;
  logic [AW-1:0]                 refuse_addr;
  sfp_pkg::sfp_stat_t            stat;
  sfp_pkg::sfp_scan_t            scan_st;
  sfp_pkg::sfp_scan_t            next_scan_st;
  logic [sfp_pkg::IDX_W-1:0]     scan_idx;
  logic [DW-1:0]                 csum;
  logic [DW-1:0]                 aux_word;

  // database occupies the low 64 bytes, holes included
  assign rom_hit = addr < sfp_pkg::ROM_TOP;

  // writes into the database are dropped and only logged
  assign refuse_evt = wr && rom_hit;

  assign rescan = wr && (addr == sfp_pkg::OFF_CTRL)
                  && wdata[sfp_pkg::CTRL_RESCAN];

  assign clr_refused = wr && (addr == sfp_pkg::OFF_STAT)
                       && wdata[sfp_pkg::STAT_REFUSED];

  // control: counting of refused writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_en <= sfp_pkg::CTRL_CNT_EN_RST;
    end else if (wr && addr == sfp_pkg::OFF_CTRL) begin
      cnt_en <= wdata[sfp_pkg::CTRL_CNT_EN];
    end
  end

  // sticky refused flag; a new refusal beats the clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat.refused <= 1'b0;
    end else if (refuse_evt) begin
      stat.refused <= 1'b1;
    end else if (clr_refused) begin
      stat.refused <= 1'b0;
    end
  end

  // saturating counter so software never sees a wrap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refuse_cnt <= '0;
    end else if (refuse_evt && cnt_en && refuse_cnt != RCNT_MAX) begin
      refuse_cnt <= refuse_cnt + RCNT_ONE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refuse_addr <= '0;
    end else if (refuse_evt) begin
      refuse_addr <= addr;
    end
  end

  // integrity scan over all sixteen words after reset or on request
  always_comb begin
    next_scan_st = scan_st;
    case (scan_st)
      sfp_pkg::SCAN_IDLE: begin
        next_scan_st = sfp_pkg::SCAN_RUN;
      end
      sfp_pkg::SCAN_RUN: begin
        if (scan_idx == IDX_LAST) begin
          next_scan_st = sfp_pkg::SCAN_DONE;
        end
      end
      sfp_pkg::SCAN_DONE: begin
        if (rescan) begin
          next_scan_st = sfp_pkg::SCAN_IDLE;
        end
      end
      default: begin
        next_scan_st = sfp_pkg::SCAN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scan_st <= sfp_pkg::SCAN_IDLE;
    end else begin
      scan_st <= next_scan_st;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scan_idx <= '0;
      csum     <= '0;
    end else if (scan_st == sfp_pkg::SCAN_IDLE) begin
      scan_idx <= '0;
      csum     <= '0;
    end else if (scan_st == sfp_pkg::SCAN_RUN) begin
      scan_idx <= scan_idx + IDX_ONE;
      csum     <= csum + sfp_pkg::rom_word(scan_idx);
    end
  end

  // signature checked while the scan passes word zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat.sig_ok <= 1'b0;
    end else if (scan_st == sfp_pkg::SCAN_IDLE) begin
      stat.sig_ok <= 1'b0;
    end else if (scan_st == sfp_pkg::SCAN_RUN && scan_idx == '0) begin
      stat.sig_ok <= sfp_pkg::rom_word(scan_idx) == sfp_pkg::W_SIG;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat.scan_done <= 1'b0;
      scan_ok        <= 1'b0;
    end else begin
      stat.scan_done <= next_scan_st == sfp_pkg::SCAN_DONE;
      scan_ok        <= next_scan_st == sfp_pkg::SCAN_DONE && stat.sig_ok;
    end
  end

  // own registers beside the database; unmapped reads give zero
  always_comb begin
    aux_word = '0;
    case (addr)
      sfp_pkg::OFF_CTRL: aux_word = DW'(cnt_en);
      sfp_pkg::OFF_STAT: aux_word = DW'(stat);
      sfp_pkg::OFF_RCNT: aux_word = DW'(refuse_cnt);
      sfp_pkg::OFF_RADR: aux_word = DW'(refuse_addr);
      sfp_pkg::OFF_CSUM: aux_word = csum;
      default:           aux_word = '0;
    endcase
  end

  // table lookup and read register live in the memory module
  sfp_rom_mem #(
    .DEPTH (sfp_pkg::DEPTH),
    .IDX_W (sfp_pkg::IDX_W),
    .DW    (DW)
  ) u_mem (
    .clock    (clock),
    .reset_n  (reset_n),
    .rd_en    (rd),
    .rom_hit  (rom_hit),
    .index    (addr[5:2]),
    .aux_word (aux_word),
    .q        (rdata)
  );

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_rd(logic [AW-1:0] a);
    rd && addr == a;
  endsequence

  sequence s_rd_rom;
    rd && addr < sfp_pkg::ROM_TOP;
  endsequence

  sequence s_rd_hole;
    rd && addr >= 8'h10 && addr < sfp_pkg::OFF_TBL1;
  endsequence

  chk_sig_word: assert property (
    s_rd(sfp_pkg::OFF_SIG) |=> rdata == 32'h50444653)
    else $error("signature word wrong");

  chk_sig_order: assert property (
    s_rd(sfp_pkg::OFF_SIG) |=> rdata[7:0] == 8'h53 && rdata[31:24] == 8'h50)
    else $error("signature byte order wrong");

  chk_hdr_count: assert property (
    s_rd(sfp_pkg::OFF_REV) |=> rdata[23:16] == 8'h00
                               && rdata[31:24] == 8'hFF)
    else $error("header count or unused byte wrong");

  chk_hdr_id: assert property (
    s_rd(sfp_pkg::OFF_HDR0) ##1 s_rd(sfp_pkg::OFF_HDR1)
    |-> rdata[7:0] == 8'h00 ##1 rdata[31:24] == 8'hFF)
    else $error("parameter id halves wrong");

  chk_id_low: assert property (
    s_rd(sfp_pkg::OFF_HDR0) |=> rdata[7:0] == 8'h00)
    else $error("parameter id low byte wrong");

  chk_tbl_rev: assert property (
    s_rd(sfp_pkg::OFF_HDR0) |=> rdata[31:8] == 24'h100106)
    else $error("table length or revision wrong");

  chk_tbl_ptr: assert property (
    s_rd(sfp_pkg::OFF_HDR1) |=> rdata[23:0] == 24'h000030)
    else $error("table pointer wrong");

  chk_erase_gran: assert property (
    s_rd(sfp_pkg::OFF_TBL1) |=> rdata[2:0] == 3'h5 && rdata[15:8] == 8'h20)
    else $error("erase field wrong");

  chk_erase_rsvd: assert property (
    s_rd(sfp_pkg::OFF_TBL1) |=> rdata[4:3] == 2'h0 && rdata[7:5] == 3'h7)
    else $error("volatile or unused bits wrong");

  chk_caps_byte: assert property (
    s_rd(sfp_pkg::OFF_TBL1) |=> rdata[23:16] == 8'hFB)
    else $error("capability byte wrong");

  chk_density: assert property (
    s_rd(sfp_pkg::OFF_TBL2) |=> rdata == 32'h07FFFFFF)
    else $error("density wrong");

  chk_rsvd_33: assert property (
    s_rd(sfp_pkg::OFF_TBL1) |=> rdata[31:24] == 8'hFF)
    else $error("reserved byte wrong");

  chk_quad_144: assert property (
    s_rd(sfp_pkg::OFF_TBL3) |=> rdata[15:0] == 16'hEB44)
    else $error("1-4-4 entry wrong");

  chk_quad_114: assert property (
    s_rd(sfp_pkg::OFF_TBL3) |=> rdata[31:16] == 16'h6B08)
    else $error("1-1-4 entry wrong");

  chk_dual_112: assert property (
    s_rd(sfp_pkg::OFF_TBL4) |=> rdata[15:0] == 16'h3B08)
    else $error("1-1-2 entry wrong");

  chk_dual_122: assert property (
    s_rd(sfp_pkg::OFF_TBL4) |=> rdata[31:16] == 16'hBB80)
    else $error("1-2-2 entry wrong");

  chk_rom_stable: assert property (
    s_rd_rom ##1 (s_rd_rom and $stable(addr)) |=> rdata == $past(rdata))
    else $error("repeated read differs");

  chk_write_ignored: assert property (
    (wr && addr == sfp_pkg::OFF_SIG) ##1 s_rd(sfp_pkg::OFF_SIG)
    |=> rdata == 32'h50444653)
    else $error("write altered database");

  chk_refused_set: assert property (
    wr && addr < sfp_pkg::ROM_TOP
    |=> stat.refused && refuse_addr == $past(addr))
    else $error("refused write not logged");

  chk_scan_bound: assert property (
    rescan && scan_st == sfp_pkg::SCAN_DONE
    |=> !stat.scan_done ##[17:18] stat.scan_done && stat.sig_ok)
    else $error("scan did not finish in time");

  chk_hole_fill: assert property (
    s_rd_hole |=> rdata == sfp_pkg::W_HOLE)
    else $error("unused word not all ones");

  chk_unmapped_zero: assert property (
    rd && addr > sfp_pkg::OFF_CSUM |=> rdata == '0)
    else $error("unmapped read not zero");

  chk_ctrl_read: assert property (
    s_rd(sfp_pkg::OFF_CTRL) |=> rdata[DW-1:1] == '0)
    else $error("control upper bits not zero");

  chk_stat_upper: assert property (
    s_rd(sfp_pkg::OFF_STAT) |=> rdata[DW-1:3] == '0)
    else $error("status upper bits not zero");

  chk_refused_clear: assert property (
    clr_refused |=> !stat.refused)
    else $error("refused flag not cleared");

  chk_cnt_step: assert property (
    refuse_evt && cnt_en && refuse_cnt != RCNT_MAX
    |=> refuse_cnt == $past(refuse_cnt) + RCNT_ONE)
    else $error("refused count did not step");

  chk_cnt_hold: assert property (
    !refuse_evt |=> $stable(refuse_cnt))
    else $error("refused count moved without a refusal");

  chk_cnt_off: assert property (
    refuse_evt && !cnt_en |=> $stable(refuse_cnt))
    else $error("refused count moved while disabled");

  chk_radr_hold: assert property (
    !refuse_evt |=> $stable(refuse_addr))
    else $error("refused address moved without a refusal");

  chk_rdata_hold: assert property (
    !rd |=> $stable(rdata))
    else $error("read data moved without a read");

  chk_scan_ok_sig: assert property (
    scan_ok |-> stat.scan_done && stat.sig_ok)
    else $error("scan ok without signature match");

  chk_rescan_clear: assert property (
    rescan && scan_st == sfp_pkg::SCAN_DONE |=> !scan_ok)
    else $error("scan ok not dropped on restart");

  chk_scan_idle: assert property (
    scan_st == sfp_pkg::SCAN_IDLE
    |=> scan_st == sfp_pkg::SCAN_RUN && scan_idx == '0)
    else $error("scan did not start from word zero");

endmodule : sfp_param_rom
`default_nettype wire

// *** verif/sfp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
  input  wire logic        clock,
  input  wire logic [31:0] rdata,
  output var  logic [7:0]  addr,
  output var  logic [31:0] wdata,
  output var  logic        wr,
  output var  logic        rd
);
  initial begin
    addr  = 8'h00;
    wdata = 32'h0000_0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // caller enters right after a rising edge; one idle edge after each call
  // so a strobe is never lowered and raised again in one step
  task automatic write_word(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
    wdata <= ~d; // released data must not linger
    @(posedge clock);
  endtask : write_word

  // data stands from the cycle after the strobe until the next read; taken at the end of that cycle
  task automatic read_word(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask : read_word

  // two reads with no gap: strobe held, first data taken as second issues
  task automatic read_pair(input logic [7:0] a1, input logic [7:0] a2,
                           output logic [31:0] d1, output logic [31:0] d2);
    addr <= a1;
    rd   <= 1'b1;
    @(posedge clock);
    addr <= a2;
    @(posedge clock);
    rd <= 1'b0;
    d1 = rdata;
    @(posedge clock);
    d2 = rdata;
  endtask : read_pair

  // write then read of the same word with no gap between strobes
  task automatic write_read(input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
    wdata <= ~d;
    rd    <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    q = rdata;
  endtask : write_read

  // lowest address of a word sits in bits 7:0
  task automatic read_byte(input logic [7:0] a, output logic [7:0] b);
    logic [31:0] w;
    read_word({a[7:2], 2'b00}, w);
    b = w[8*a[1:0] +: 8];
  endtask : read_byte
endmodule : sfp_host_model
`default_nettype wire

// *** verif/tb_sfp_param_rom.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_sfp_param_rom;
  logic        clock;
  logic        reset_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        scan_ok;
  logic [7:0]  m [64];
  logic [31:0] got;
  logic [31:0] sum;
  logic [31:0] dens;
  logic [7:0]  b;
  int          num_errors;
  int          n_tests;
  int          cycles;
  int          a;

  sfp_param_rom sfp_param_rom_inst (
    .clock   (clock),
    .reset_n (reset_n),
    .addr    (addr),
    .wdata   (wdata),
    .wr      (wr),
    .rd      (rd),
    .rdata   (rdata),
    .scan_ok (scan_ok)
  );

  sfp_host_model sfp_host_model_inst (
    .clock (clock),
    .rdata (rdata),
    .addr  (addr),
    .wdata (wdata),
    .wr    (wr),
    .rd    (rd)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;

  function automatic logic [31:0] exp_word(input logic [7:0] x);
    logic [7:0] w;
    w = {x[7:2], 2'b00};
    return {m[w+3], m[w+2], m[w+1], m[w]};
  endfunction : exp_word

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // bounded at 40 edges: scan is short, running out here means it never finished
  task automatic wait_scan;
    for (int k = 0; k < 40 && scan_ok !== 1'b1; k++) @(posedge clock);
  endtask : wait_scan

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    reset_n    = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    cycles     = 0;
    got        = $urandom(33);
    for (a = 0; a < 64; a++) m[a] = 8'hFF;
    {m[3], m[2], m[1], m[0]} = {8'h50, 8'h44, 8'h46, 8'h53};
    {m[7], m[6], m[5], m[4]} = {8'hFF, 8'h00, 8'h01, 8'h06};
    {m[11], m[10], m[9], m[8]} = {8'h10, 8'h01, 8'h06, 8'h00};
    {m[15], m[14], m[13], m[12]} = {8'hFF, 8'h00, 8'h00, 8'h30};
    {m[49], m[48]} = {8'h20, 3'b111, 1'b0, 1'b0, 1'b1, 2'b01};
    m[50] = {4'hF, 1'b1, 2'b01, 1'b1};
    {m[55], m[54], m[53], m[52]} = {8'h07, 8'hFF, 8'hFF, 8'hFF};
    {m[57], m[56]} = {8'hEB, 3'b010, 5'b00100};
    {m[59], m[58]} = {8'h6B, 3'b000, 5'b01000};
    {m[61], m[60]} = {8'h3B, 3'b000, 5'b01000};
    {m[63], m[62]} = {8'hBB, 3'b100, 5'b00000};
    repeat (12) @(posedge clock);
    `CHK(rdata, 32'h0)
    `CHK(scan_ok, 1'b0)
    reset_n <= 1'b1;
    @(posedge clock);
    for (a = 0; a < 64; a += 4) begin
      sfp_host_model_inst.read_word(a[7:0], got);
      `CHK(got, exp_word(a[7:0]))
    end
    for (a = 0; a < 4; a++) begin
      sfp_host_model_inst.read_byte(8'h34 + a[7:0], b);
      dens[8*a +: 8] = b;
    end
    `CHK(dens, {m[55], m[54], m[53], m[52]})
    sfp_host_model_inst.read_byte(8'h06, b);
    `CHK(b, 8'h00)
    sfp_host_model_inst.read_byte(8'h0F, b);
    `CHK(b, 8'hFF)
    sfp_host_model_inst.read_pair(8'h08, 8'h0C, got, dens);
    `CHK(got, exp_word(8'h08))
    `CHK(dens, exp_word(8'h0C))
    a = $urandom_range(63);
    sfp_host_model_inst.read_pair(a[7:0], a[7:0], got, dens);
    `CHK(got, dens)
    `CHK(dens, exp_word(a[7:0]))
    $display("test map done");
    repeat (40) begin
      a = $urandom_range(63);
      sfp_host_model_inst.read_word(a[7:0], got);
      `CHK(got, exp_word(a[7:0]))
    end
    $display("test random reads done");
    wait_scan();
    `CHK(scan_ok, 1'b1)
    // refused writes with random data, then read all back
    for (a = 0; a < 64; a += 4)
      sfp_host_model_inst.write_word(a[7:0], $urandom());
    sfp_host_model_inst.write_word(8'h80, $urandom());
    for (a = 0; a < 64; a += 4) begin
      sfp_host_model_inst.read_word(a[7:0], got);
      `CHK(got, exp_word(a[7:0]))
    end
    sfp_host_model_inst.read_word(8'h48, got);
    `CHK(got, 32'h10)
    sfp_host_model_inst.read_word(8'h4C, got);
    `CHK(got, 32'h3C)
    sfp_host_model_inst.read_word(8'h44, got);
    `CHK(got, 32'h7)
    sfp_host_model_inst.write_word(8'h44, 32'h4);
    sfp_host_model_inst.read_word(8'h44, got);
    `CHK(got, 32'h3)
    sfp_host_model_inst.read_word(8'h80, got);
    `CHK(got, 32'h0)
    sfp_host_model_inst.read_word(8'h40, got);
    `CHK(got, 32'h1)
    $display("test refused writes done");
    sfp_host_model_inst.write_word(8'h40, 32'h3);
    repeat (2) @(posedge clock);
    `CHK(scan_ok, 1'b0)
    wait_scan();
    `CHK(scan_ok, 1'b1)
    sum = 32'h0;
    for (a = 0; a < 64; a += 4) sum += exp_word(a[7:0]);
    @(posedge clock);
    sfp_host_model_inst.read_word(8'h50, got);
    `CHK(got, sum)
    $display("test rescan done");
    // counting off: refusals still logged, count frozen
    sfp_host_model_inst.write_word(8'h40, 32'h0);
    sfp_host_model_inst.write_read(8'h00, $urandom(), got);
    `CHK(got, exp_word(8'h00))
    sfp_host_model_inst.write_word(8'h24, $urandom());
    sfp_host_model_inst.read_pair(8'h48, 8'h4C, got, dens);
    `CHK(got, 32'h10)
    `CHK(dens, 32'h24)
    sfp_host_model_inst.read_word(8'h40, got);
    `CHK(got, 32'h0)
    $display("test count off done");
    // reset in mid-run: counters clear, content does not move
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(rdata, 32'h0)
    `CHK(scan_ok, 1'b0)
    reset_n <= 1'b1;
    @(posedge clock);
    sfp_host_model_inst.read_word(8'h48, got);
    `CHK(got, 32'h0)
    sfp_host_model_inst.read_word(8'h3C, got);
    `CHK(got, exp_word(8'h3C))
    sfp_host_model_inst.read_word(8'h40, got);
    `CHK(got, 32'h1)
    $display("test second reset done");
    report_and_stop();
  end
endmodule : tb_sfp_param_rom
`default_nettype wire
